// ===== inc/fagp_consts.svh
// Register offsets, sense codes and reset values of the fast alias port
`ifndef FAGP_CONSTS_SVH
`define FAGP_CONSTS_SVH

`define FAGP_OFS_DIRECTION 2'h0
`define FAGP_OFS_DRIVE 2'h1
`define FAGP_OFS_SAMPLED 2'h2
`define FAGP_OFS_FLAGS 2'h3

`define FAGP_RESET_BYTE 8'h00

`define FAGP_PAD_COUNT 8
`define FAGP_SENSE_BITS 3

`define FAGP_SENSE_NOEVENT 3'h0
`define FAGP_SENSE_BOTH 3'h1
`define FAGP_SENSE_RISE 3'h2
`define FAGP_SENSE_FALL 3'h3
`define FAGP_SENSE_OFF 3'h4
`define FAGP_SENSE_LOW 3'h5

`endif

// ===== inc/fagp_pkg.sv
// Shared types of the fast alias port
package fagp_pkg;
    typedef logic [7:0] fagp_byte_type;
    typedef logic [1:0] fagp_addr_type;
    typedef logic [2:0] fagp_sense_type;
    typedef logic [23:0] fagp_sense_bus_type;
endpackage

// ===== logic/fagp_port.sv
// Eight-pad port reached through the fast alias register window
`timescale 1ns/10ps
`include "fagp_consts.svh"

module fagp_port (
    input wire logic clock, // System clock, 20 MHz
    input wire logic reset, // Synchronous, active high
    input wire fagp_pkg::fagp_addr_type address, // Register offset
    input wire logic writeEnable, // One-cycle write strobe
    input wire fagp_pkg::fagp_byte_type writeData, // Write data
    input wire logic readEnable, // One-cycle read strobe
    output fagp_pkg::fagp_byte_type readData, // Read data, next cycle
    input wire fagp_pkg::fagp_sense_bus_type senseConfig, // 3 bits per pad
    input wire fagp_pkg::fagp_byte_type padIn, // Pad levels
    output fagp_pkg::fagp_byte_type padOut, // Pad drive levels
    output fagp_pkg::fagp_byte_type padOutEnable // Pad driver enables
);

    fagp_pkg::fagp_byte_type padSync1;
    fagp_pkg::fagp_byte_type padSync2;
    fagp_pkg::fagp_byte_type prevLevel;
    fagp_pkg::fagp_byte_type sampledLevel;
    fagp_pkg::fagp_byte_type eventFlags;
    fagp_pkg::fagp_byte_type setEvent;
    fagp_pkg::fagp_byte_type bufferOff;
    logic writeDirection;
    logic writeDrive;
    logic writeSampled;
    logic writeFlags;

    assign writeDirection = writeEnable && address == `FAGP_OFS_DIRECTION;
    assign writeDrive = writeEnable && address == `FAGP_OFS_DRIVE;
    assign writeSampled = writeEnable && address == `FAGP_OFS_SAMPLED;
    assign writeFlags = writeEnable && address == `FAGP_OFS_FLAGS;

    // Runs through reset, so no false edge follows it; stage one feeds two
    always_ff @(posedge clock) begin
        padSync1 <= padIn;
        padSync2 <= padSync1;
        prevLevel <= padSync2;
    end

    // Per-pad sense decode
    genvar n;
    generate
        for (n = 0; n < `FAGP_PAD_COUNT; n++) begin : gPad
            fagp_pkg::fagp_sense_type sense;
            assign sense = senseConfig[`FAGP_SENSE_BITS*n +: `FAGP_SENSE_BITS];
            assign bufferOff[n] = sense == `FAGP_SENSE_OFF;
            always_comb begin
                case (sense)
                    `FAGP_SENSE_BOTH:
                        setEvent[n] = padSync2[n] != prevLevel[n];
                    `FAGP_SENSE_RISE:
                        setEvent[n] = padSync2[n] && !prevLevel[n];
                    `FAGP_SENSE_FALL:
                        setEvent[n] = !padSync2[n] && prevLevel[n];
                    `FAGP_SENSE_LOW:
                        setEvent[n] = !padSync2[n];
                    default:
                        setEvent[n] = 1'h0;
                endcase
            end
        end
    endgenerate

    // Buffer off: sampling stops, value held
    always_ff @(posedge clock) begin
        if (reset) begin
            sampledLevel <= `FAGP_RESET_BYTE;
        end else begin
            sampledLevel <= (padSync2 & ~bufferOff)
                | (sampledLevel & bufferOff);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            padOutEnable <= `FAGP_RESET_BYTE;
        end else if (writeDirection) begin
            padOutEnable <= writeData;
        end
    end

    // Pad level is the drive bit; the pad ignores it while enable is low
    always_ff @(posedge clock) begin
        if (reset) begin
            padOut <= `FAGP_RESET_BYTE;
        end else if (writeDrive) begin
            padOut <= writeData;
        end else if (writeSampled) begin
            padOut <= padOut ^ writeData;
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            eventFlags <= `FAGP_RESET_BYTE;
        end else if (writeFlags) begin
            eventFlags <= (eventFlags & ~writeData) | setEvent;
        end else begin
            eventFlags <= eventFlags | setEvent;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            readData <= `FAGP_RESET_BYTE;
        end else if (readEnable) begin
            case (address)
                `FAGP_OFS_DIRECTION: readData <= padOutEnable;
                `FAGP_OFS_DRIVE: readData <= padOut;
                `FAGP_OFS_SAMPLED: readData <= sampledLevel;
                `FAGP_OFS_FLAGS: readData <= eventFlags;
                default: readData <= `FAGP_RESET_BYTE;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_direction;
        writeDirection |=> padOutEnable == $past(writeData);
    endproperty
    a_direction: assert property (p_direction)
        else $error("direction write not applied");

    property p_enable_stable;
        !writeDirection |=> $stable(padOutEnable);
    endproperty
    a_enable_stable: assert property (p_enable_stable)
        else $error("driver enable changed without direction write");

    property p_drive;
        writeDrive |=> padOut == $past(writeData);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive level write not applied");

    property p_drive_hold;
        !writeDrive && !writeSampled |=> $stable(padOut);
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("drive level changed without a write");

    property p_track;
        1'h1 |=> (sampledLevel & ~$past(bufferOff))
            == ($past(padSync2) & ~$past(bufferOff));
    endproperty
    a_track: assert property (p_track)
        else $error("sampled level does not track pad");

    property p_hold;
        1'h1 |=> ((sampledLevel ^ $past(sampledLevel))
            & $past(bufferOff)) == 8'h00;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sampled level changed with buffer off");

    property p_toggle;
        writeSampled |=> padOut == ($past(padOut) ^ $past(writeData));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle write wrong");

    property p_set;
        1'h1 |=> (eventFlags & $past(setEvent)) == $past(setEvent);
    endproperty
    a_set: assert property (p_set)
        else $error("event flag not set");

    property p_clear;
        writeFlags |=> (eventFlags & $past(writeData)
            & ~$past(setEvent)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("event flag not cleared");

    property p_read_drive;
        readEnable && address == `FAGP_OFS_DRIVE |=> readData == $past(padOut);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read of drive level wrong");

    property p_rise;
        senseConfig[2:0] == `FAGP_SENSE_RISE && padSync2[0] && !prevLevel[0]
            |=> eventFlags[0];
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising edge missed");

    property p_off;
        (setEvent & bufferOff) == 8'h00;
    endproperty
    a_off: assert property (p_off)
        else $error("event with buffer off");

    property p_sync;
        ##2 padSync2 == $past(padIn, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchroniser depth wrong");

    property p_reset_clear;
        disable iff (1'h0) reset |=> padOutEnable == `FAGP_RESET_BYTE
            && padOut == `FAGP_RESET_BYTE && eventFlags == `FAGP_RESET_BYTE;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("registers not cleared by reset");

    property p_clear_zero;
        writeFlags |=> ($past(eventFlags) & ~$past(writeData)
            & ~eventFlags) == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("flag written zero was cleared");

    property p_no_spurious;
        1'h1 |=> (eventFlags & ~$past(eventFlags) & ~$past(setEvent))
            == 8'h00;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("event flag set without a matching event");

    property p_both;
        gPad[3].sense == `FAGP_SENSE_BOTH && padSync2[3] != prevLevel[3]
            |=> eventFlags[3];
    endproperty
    a_both: assert property (p_both)
        else $error("change missed in both-edge mode");

    property p_fall;
        gPad[1].sense == `FAGP_SENSE_FALL && !padSync2[1] && prevLevel[1]
            |=> eventFlags[1];
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling edge missed");

    property p_low;
        gPad[2].sense == `FAGP_SENSE_LOW && !padSync2[2] |=> eventFlags[2];
    endproperty
    a_low: assert property (p_low)
        else $error("low level missed");

    property p_no_event;
        gPad[4].sense == `FAGP_SENSE_NOEVENT |-> !setEvent[4];
    endproperty
    a_no_event: assert property (p_no_event)
        else $error("event raised in no-event mode");

    property p_off_hold;
        gPad[5].sense == `FAGP_SENSE_OFF |=> $stable(sampledLevel[5]);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("sampled level moved with buffer off");

    property p_read_flags;
        readEnable && address == `FAGP_OFS_FLAGS
            |=> readData == $past(eventFlags);
    endproperty
    a_read_flags: assert property (p_read_flags)
        else $error("read of event flags wrong");

    property p_read_hold;
        !readEnable |=> $stable(readData);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data changed without a read");

    property p_cov_event;
        |setEvent ##1 writeFlags;
    endproperty
    c_event: cover property (p_cov_event);

    property p_cov_toggle;
        writeDirection ##1 writeSampled;
    endproperty
    c_toggle: cover property (p_cov_toggle);

    property p_cov_set_clear;
        writeFlags && |(setEvent & writeData);
    endproperty
    c_set_clear: cover property (p_cov_set_clear);

    property p_cov_low;
        gPad[2].sense == `FAGP_SENSE_LOW && setEvent[2] && writeFlags;
    endproperty
    c_low: cover property (p_cov_low);

    property p_cov_off_hold;
        bufferOff[5] && padSync2[5] != sampledLevel[5];
    endproperty
    c_off_hold: cover property (p_cov_off_hold);

endmodule

// ===== test/fagp_pad_model.sv
// Pad-side partner: each pad follows its driver or the outside level
`timescale 1ns/10ps

module fagp_pad_model (
    input wire fagp_pkg::fagp_byte_type padOut, // Drive levels
    input wire fagp_pkg::fagp_byte_type padOutEnable, // Driver enables
    input wire fagp_pkg::fagp_byte_type extLevel, // Outside source level
    output fagp_pkg::fagp_byte_type padIn // Level on each pad
);
    // An enabled driver wins, otherwise the outside source sets the pad
    assign padIn = (padOutEnable & padOut) | (~padOutEnable & extLevel);
endmodule

// ===== test/tb.sv
// Self-checking bench of the fast alias port against a reference model
`timescale 1ns/10ps
`include "fagp_consts.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    miscompares++; $display("Error %s expected %h seen %h", nm, ex, got); \
    end end

module tb;
    logic clock = 1'h0;
    logic reset = 1'h1;
    fagp_pkg::fagp_addr_type address = 2'h0;
    logic writeEnable = 1'h0;
    logic readEnable = 1'h0;
    fagp_pkg::fagp_byte_type writeData = 8'h00;
    fagp_pkg::fagp_sense_bus_type senseConfig = 24'h000000;
    fagp_pkg::fagp_byte_type extLevel = 8'h00;
    fagp_pkg::fagp_byte_type padIn, padOut, padOutEnable, readData;
    int miscompares = 0;
    int checked = 0;
    logic [7:0] mDir, mDrv, mSamp, mFlg, s1, s2, prv, rdExp, setV, bufOn;
    logic [7:0] rdHeld;
    logic [7:0] rdQ[$];
    logic [2:0] code;

    fagp_port u_fagp_port (.clock(clock), .reset(reset), .address(address),
        .writeEnable(writeEnable), .writeData(writeData),
        .readEnable(readEnable), .readData(readData),
        .senseConfig(senseConfig), .padIn(padIn), .padOut(padOut),
        .padOutEnable(padOutEnable));
    fagp_pad_model u_fagp_pad_model (.padOut(padOut),
        .padOutEnable(padOutEnable), .extLevel(extLevel), .padIn(padIn));

    initial begin
        forever #25 clock = ~clock;
    end

    // Reference model: two-stage sync, delayed copy for edges
    always @(posedge clock) begin
        if (reset) begin
            {mDir, mDrv, mSamp, mFlg} = '0;
            rdQ.delete();
        end else begin
            for (int n = 0; n < 8; n++) begin
                code = senseConfig[3*n +: 3];
                bufOn[n] = (code != `FAGP_SENSE_OFF);
                case (code)
                    `FAGP_SENSE_BOTH: setV[n] = s2[n] ^ prv[n];
                    `FAGP_SENSE_RISE: setV[n] = s2[n] & ~prv[n];
                    `FAGP_SENSE_FALL: setV[n] = ~s2[n] & prv[n];
                    `FAGP_SENSE_LOW: setV[n] = ~s2[n];
                    default: setV[n] = 1'h0;
                endcase
            end
            if (readEnable) begin
                case (address)
                    `FAGP_OFS_DIRECTION: rdExp = mDir;
                    `FAGP_OFS_DRIVE: rdExp = mDrv;
                    `FAGP_OFS_SAMPLED: rdExp = mSamp;
                    default: rdExp = mFlg;
                endcase
                rdQ.push_back(rdExp);
            end
            if (writeEnable) begin
                case (address)
                    `FAGP_OFS_DIRECTION: mDir = writeData;
                    `FAGP_OFS_DRIVE: mDrv = writeData;
                    `FAGP_OFS_SAMPLED: mDrv = mDrv ^ writeData;
                    default: mFlg = mFlg & ~writeData;
                endcase
            end
            mFlg = mFlg | setV;
            mSamp = (mSamp & ~bufOn) | (s2 & bufOn);
        end
        // Synchroniser copy keeps running through reset, as in the design
        prv = s2;
        s2 = s1;
        s1 = padIn;
    end

    // Read data stands from the edge after the read until the next read
    always @(negedge clock) begin
        if (reset) begin
            rdHeld = 8'h00;
        end else begin
            if (rdQ.size() > 0) begin
                rdHeld = rdQ.pop_front();
            end
            `CHK("padOut", mDrv, padOut)
            `CHK("padOutEnable", mDir, padOutEnable)
            `CHK("readData", rdHeld, readData)
        end
    end

    task automatic final_report();
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32));
        repeat (4) @(negedge clock);
        reset <= 1'h0;
        for (int ph = 0; ph < 12; ph++) begin
            @(negedge clock);
            writeEnable <= 1'h0;
            readEnable <= 1'h0;
            // A second reset in mid-run, with the pads left where they are
            if (ph == 8) begin
                reset <= 1'h1;
                repeat (2) @(negedge clock);
                reset <= 1'h0;
            end
            repeat (5) @(negedge clock);
            // Every sense code on all pads first, then mixed and reserved
            for (int n = 0; n < 8; n++) begin
                senseConfig[3*n +: 3] <= (ph < 6) ? 3'(ph) : 3'($urandom % 8);
            end
            // Random byte-port traffic and outside pad activity
            repeat (400) begin
                @(negedge clock);
                address <= 2'($urandom);
                writeData <= 8'($urandom);
                writeEnable <= ($urandom % 4 == 0);
                readEnable <= ($urandom % 2 == 0);
                if ($urandom % 8 == 0) begin
                    extLevel <= extLevel ^ (8'h01 << ($urandom % 8));
                end
            end
        end
        final_report();
    end
endmodule
